// [rtl/flo_defs.svh]
// Offsets, field positions and reset values for the fabric login option block
`ifndef FLO_DEFS_SVH
`define FLO_DEFS_SVH
`define FLO_AW 8
`define FLO_OFF_CTRL 8'h00
`define FLO_OFF_CMD 8'h04
`define FLO_OFF_STAT 8'h08
`define FLO_OFF_REQ1 8'h10
`define FLO_OFF_REQ2 8'h14
`define FLO_OFF_REQ3 8'h18
`define FLO_OFF_ACC_LO 8'h40
`define FLO_OFF_ACC_HI 8'h6c
`define FLO_ACC_WORDS 12
`define FLO_GRP_WORDS 4
`define FLO_NCLASS 3
`define FLO_CTRL_RST 32'h0000_0000
`define FLO_B_VALID 31
`define FLO_B_INTERMIX 30
`define FLO_B_TRANSP 29
`define FLO_B_LOCKDN 28
`define FLO_B_SEQDEL 27
`define FLO_B_RSV_HI 26
`define FLO_B_RSV_LO 16
`define FLO_FCTL_UNIDIR 8
`define FLO_C_EN_LO 0
`define FLO_C_INTERMIX 3
`define FLO_C_TRANSP 4
`define FLO_C_LOCKDN 5
`define FLO_C_SEQ2 6
`define FLO_C_SEQ3 7
`define FLO_CMD_START 0
`define FLO_EVAL_MIN 6
`define FLO_EVAL_MAX 12
`endif

// [rtl/flo_mem.sv]
// Small word store for the received accept payload, registered read data
`timescale 1ns/100ps
module flo_mem (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] rd_addr,
  output logic [31:0] rd_data
);
  logic [31:0] mem [0:15];

  // Write port
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// [rtl/flo_pkg.sv]
// Types shared by the fabric login option block
package flo_pkg;
  typedef enum logic [3:0] {
    FLO_S_IDLE = 4'h1,
    FLO_S_READ = 4'h2,
    FLO_S_EVAL = 4'h4,
    FLO_S_DONE = 4'h8
  } flo_state_e;
  typedef enum logic [1:0] {
    FLO_CONN_IDLE = 2'h0,
    FLO_CONN_PENDING = 2'h1,
    FLO_CONN_ESTAB = 2'h2,
    FLO_CONN_COMPLETE = 2'h3
  } flo_conn_e;
  // Frame offered by the transmit path for admission
  typedef struct packed {
    logic valid;
    logic [1:0] cls;
    logic conn_req;
    logic [23:0] dest;
  } flo_txreq_s;
  // Options that the login made functional
  typedef struct packed {
    logic [2:0] cls_ok;
    logic intermix;
    logic transp;
    logic lockdn;
    logic seq2;
    logic seq3;
  } flo_opts_s;
endpackage

// [rtl/flo_top.sv]
// Fabric login class option negotiation and frame admission for a node port
// Notes on behaviour
// - Class group counts only when its validity bit 31 is one.
// - Group position gives the class: first one, second two, third three.
// - Service option bits 26 to 16 are reserved.
// - Intermix works only if requested and granted in bit 30.
// - Bits 30, 29, 28 are reserved for classes two and three.
// - During a class one connection, talk only to the partner port.
// - Stacking modes are requested only together with intermix.
// - Stacked connect-requests may go in any connection state.
// - Transparent mode lets destination send data after its acknowledge.
// - Lock-down connect-request sets unidirectional bit; destination then sends no data.
// - Bit 29 transparent, bit 28 lock-down; fabric grants at most one.
// - Transparent stacking works only if requested and granted in bit 29.
// - Lock-down stacking works only if requested and granted in bit 28.
// - Bit 27 requests in-order delivery; granted when accept returns it.
// - Control flags and receive size fields are ignored at fabric login.
`timescale 1ns/100ps
`include "flo_defs.svh"
module flo_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire flo_pkg::flo_txreq_s tx_req,
  output logic tx_ok,
  output logic tx_fctl_unidir,
  input wire flo_pkg::flo_conn_e conn_state,
  input wire logic [23:0] conn_partner,
  input wire logic rx_cr_ack,
  input wire logic rx_cr_unidir,
  output flo_pkg::flo_opts_s opts
);
  logic [31:0] ctrl_reg;
  logic [31:0] req_w [0:2];
  flo_pkg::flo_state_e state_reg;
  logic [1:0] grp_reg;
  logic done_reg;
  logic stack_err_reg;
  logic inhibit_reg;
  logic [31:0] rdata_reg;
  logic rd_mem_reg;
  logic [31:0] mem_q;
  logic start;
  logic acc_hit;
  logic bus_mem_rd;
  logic [3:0] mem_raddr;
  logic busy_c1;
  logic [31:0] stat_w;

  // Builds the request word 0 for one class from the control register
  function automatic logic [31:0] req_word(input logic [1:0] k, input logic [31:0] c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`FLO_B_VALID] = c[`FLO_C_EN_LO + k];
    if (k == 2'h0) begin
      w[`FLO_B_INTERMIX] = c[`FLO_C_INTERMIX];
      w[`FLO_B_TRANSP] = c[`FLO_C_INTERMIX] & c[`FLO_C_TRANSP];
      w[`FLO_B_LOCKDN] = c[`FLO_C_INTERMIX] & c[`FLO_C_LOCKDN];
    end else if (k == 2'h1) begin
      w[`FLO_B_SEQDEL] = c[`FLO_C_SEQ2];
    end else begin
      w[`FLO_B_SEQDEL] = c[`FLO_C_SEQ3];
    end
    return w;
  endfunction

  // Address decode of the accept payload window
  function automatic logic acc_range(input logic [7:0] a);
    return (a >= `FLO_OFF_ACC_LO) && (a <= `FLO_OFF_ACC_HI) && (a[1:0] == 2'h0);
  endfunction

  // Request words, reserved and meaningless bits held at zero
  // stacking gated by intermix
  // bits 26 to 16 carry no option
  genvar gi;
  generate
    for (gi = 0; gi < `FLO_NCLASS; gi = gi + 1) begin : g_req
      assign req_w[gi] = req_word(2'(gi), ctrl_reg);
    end
  endgenerate

  assign acc_hit = acc_range(bus_addr);
  assign start = bus_wr && (bus_addr == `FLO_OFF_CMD) && bus_wdata[`FLO_CMD_START] && (state_reg == flo_pkg::FLO_S_IDLE);
  assign bus_mem_rd = bus_rd && acc_hit;
  // Bus reads take the memory port first; the walk waits a cycle
  assign mem_raddr = bus_mem_rd ? 4'(bus_addr[5:2] - 4'h0) : {grp_reg, 2'h0};

  flo_mem u_mem (
    .sys_clk(sys_clk),
    .wr_en(bus_wr && acc_hit),
    .wr_addr(bus_addr[5:2]),
    .wr_data(bus_wdata),
    .rd_addr(mem_raddr),
    .rd_data(mem_q)
  );

  // Control register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_reg <= `FLO_CTRL_RST;
    end else if (bus_wr && bus_addr == `FLO_OFF_CTRL) begin
      ctrl_reg <= {24'h000000, bus_wdata[7:0]};
    end
  end

  // Walk over the three accept groups, word 0 only
  // control and size words never fetched
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= flo_pkg::FLO_S_IDLE;
      grp_reg <= 2'h0;
    end else begin
      case (state_reg)
        flo_pkg::FLO_S_IDLE: begin
          if (start) begin
            state_reg <= flo_pkg::FLO_S_READ;
            grp_reg <= 2'h0;
          end
        end
        flo_pkg::FLO_S_READ: begin
          if (!bus_mem_rd) begin
            state_reg <= flo_pkg::FLO_S_EVAL;
          end
        end
        flo_pkg::FLO_S_EVAL: begin
          if (grp_reg == 2'h2) begin
            state_reg <= flo_pkg::FLO_S_DONE;
          end else begin
            grp_reg <= grp_reg + 2'h1;
            state_reg <= flo_pkg::FLO_S_READ;
          end
        end
        flo_pkg::FLO_S_DONE: begin
          state_reg <= flo_pkg::FLO_S_IDLE;
        end
        default: begin
          state_reg <= flo_pkg::FLO_S_IDLE;
        end
      endcase
    end
  end

  // Option results, the accept word compared with the request word
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      opts <= '0;
      stack_err_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (start) begin
      opts <= '0;
      stack_err_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (state_reg == flo_pkg::FLO_S_DONE) begin
      done_reg <= 1'b1;
    end else if (state_reg == flo_pkg::FLO_S_EVAL) begin
      opts.cls_ok[grp_reg] <= req_w[grp_reg][`FLO_B_VALID] & mem_q[`FLO_B_VALID];
      if (mem_q[`FLO_B_VALID] && grp_reg == 2'h0) begin
        opts.intermix <= req_w[0][`FLO_B_INTERMIX] & mem_q[`FLO_B_INTERMIX];
        if (req_w[0][`FLO_B_TRANSP] & mem_q[`FLO_B_TRANSP] & req_w[0][`FLO_B_LOCKDN] & mem_q[`FLO_B_LOCKDN]) begin
          stack_err_reg <= 1'b1;
        end else begin
          opts.transp <= req_w[0][`FLO_B_TRANSP] & mem_q[`FLO_B_TRANSP];
          opts.lockdn <= req_w[0][`FLO_B_LOCKDN] & mem_q[`FLO_B_LOCKDN];
        end
      end
      // sequential delivery, classes two and three
      // bits 30 to 28 ignored here
      if (mem_q[`FLO_B_VALID] && grp_reg == 2'h1) begin
        opts.seq2 <= req_w[1][`FLO_B_SEQDEL] & mem_q[`FLO_B_SEQDEL];
      end
      if (mem_q[`FLO_B_VALID] && grp_reg == 2'h2) begin
        opts.seq3 <= req_w[2][`FLO_B_SEQDEL] & mem_q[`FLO_B_SEQDEL];
      end
    end
  end

  // Lock-down destination hold-off after acknowledging a connect-request
  // no data after unidirectional acknowledge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      inhibit_reg <= 1'b0;
    end else if (rx_cr_ack && rx_cr_unidir) begin
      inhibit_reg <= 1'b1;
    end else if (conn_state == flo_pkg::FLO_CONN_IDLE || conn_state == flo_pkg::FLO_CONN_COMPLETE) begin
      inhibit_reg <= 1'b0;
    end
  end

  // Frame admission
  assign busy_c1 = (conn_state == flo_pkg::FLO_CONN_PENDING) || (conn_state == flo_pkg::FLO_CONN_ESTAB);
  always_comb begin
    tx_ok = 1'b0;
    if (tx_req.valid && tx_req.cls >= 2'h1) begin
      if (!opts.cls_ok[tx_req.cls - 2'h1]) begin
        tx_ok = 1'b0;
      end else if (tx_req.cls == 2'h1 && tx_req.conn_req) begin
        tx_ok = (opts.transp | opts.lockdn) | (conn_state == flo_pkg::FLO_CONN_IDLE);
      end else if (inhibit_reg && tx_req.dest == conn_partner) begin
        tx_ok = 1'b0;
      end else if (tx_req.cls == 2'h1) begin
        tx_ok = (conn_state == flo_pkg::FLO_CONN_ESTAB) && (tx_req.dest == conn_partner);
      end else begin
        tx_ok = !busy_c1 || opts.intermix || (tx_req.dest == conn_partner);
      end
    end
  end
  assign tx_fctl_unidir = tx_req.valid && tx_req.conn_req && (tx_req.cls == 2'h1) && opts.lockdn;

  // Status word
  assign stat_w = {20'h00000, inhibit_reg, stack_err_reg, opts.seq3, opts.seq2, opts.lockdn, opts.transp,
                   opts.intermix, opts.cls_ok, done_reg, (state_reg != flo_pkg::FLO_S_IDLE)};

  // Register read, data in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_reg <= 32'h0000_0000;
      rd_mem_reg <= 1'b0;
    end else begin
      rd_mem_reg <= bus_mem_rd;
      rdata_reg <= 32'h0000_0000;
      if (bus_rd) begin
        case (bus_addr)
          `FLO_OFF_CTRL: rdata_reg <= ctrl_reg;
          `FLO_OFF_STAT: rdata_reg <= stat_w;
          `FLO_OFF_REQ1: rdata_reg <= req_w[0];
          `FLO_OFF_REQ2: rdata_reg <= req_w[1];
          `FLO_OFF_REQ3: rdata_reg <= req_w[2];
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign bus_rdata = rd_mem_reg ? mem_q : rdata_reg;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_req_reserved: assert property (req_w[0][26:16] == 11'h000 && req_w[1][30:28] == 3'h0)
    else $error("Reserved request bits not zero");
  a_stack_intermix: assert property ((req_w[0][29] | req_w[0][28]) |-> req_w[0][30])
    else $error("Stacking requested without intermix");
  a_one_mode: assert property (!(opts.transp && opts.lockdn))
    else $error("Both stacking modes functional");
  a_intermix_req: assert property ($rose(opts.intermix) |-> $past(ctrl_reg[3]) && $past(mem_q[30]))
    else $error("Intermix functional without both bits");
  a_exclusive_tx: assert property (tx_req.valid && busy_c1 && !opts.intermix && tx_req.dest != conn_partner
    && !tx_req.conn_req |-> !tx_ok)
    else $error("Frame to third port during connection");
  a_lock_tag: assert property (tx_ok && tx_req.conn_req && tx_req.cls == 2'h1 && opts.lockdn |-> tx_fctl_unidir)
    else $error("Lock-down request without unidirectional bit");
  a_lock_hold: assert property (rx_cr_ack && rx_cr_unidir ##1 (tx_req.valid && !tx_req.conn_req
    && tx_req.dest == conn_partner) |-> !tx_ok)
    else $error("Data sent after lock-down acknowledge");
  a_stack_any: assert property (tx_req.valid && tx_req.cls == 2'h1 && tx_req.conn_req && opts.cls_ok[0]
    && (opts.transp || opts.lockdn) |-> tx_ok)
    else $error("Stacked connect-request refused");
  a_eval_bound: assert property (start |-> ##[6:12] done_reg)
    else $error("Evaluation did not finish in time");
  // Grants traced back to the request and accept words of the walk, class two and three reserved request bits, hold-off set
  a_cls_valid: assert property ($rose(opts.cls_ok[0]) |-> $past(req_w[0][`FLO_B_VALID])
    && $past(mem_q[`FLO_B_VALID]))
    else $error("Class one usable without both validity bits");
  a_resv_c23: assert property (req_w[1][30:28] == 3'h0 && req_w[2][30:28] == 3'h0
    && req_w[1][26:16] == 11'h000 && req_w[2][26:16] == 11'h000)
    else $error("Reserved bits set in a class two or three request");
  a_seq_grant: assert property ($rose(opts.seq2) |-> $past(req_w[1][`FLO_B_SEQDEL])
    && $past(mem_q[`FLO_B_SEQDEL]) && $past(mem_q[`FLO_B_VALID]))
    else $error("In-order delivery without request and grant");
  a_transp_req: assert property ($rose(opts.transp) |-> $past(req_w[0][`FLO_B_TRANSP])
    && $past(mem_q[`FLO_B_TRANSP]) && !$past(req_w[0][`FLO_B_LOCKDN] & mem_q[`FLO_B_LOCKDN]))
    else $error("Transparent mode without request and grant");
  a_lockdn_req: assert property ($rose(opts.lockdn) |-> $past(req_w[0][`FLO_B_LOCKDN])
    && $past(mem_q[`FLO_B_LOCKDN]) && !$past(req_w[0][`FLO_B_TRANSP] & mem_q[`FLO_B_TRANSP]))
    else $error("Lock-down mode without request and grant");
  a_hold_set: assert property (rx_cr_ack && rx_cr_unidir |=> inhibit_reg)
    else $error("Hold-off not set after lock-down acknowledge");

  c_intermix: cover property (opts.intermix && busy_c1 && tx_ok && tx_req.cls == 2'h2);
  c_lock_hold: cover property (inhibit_reg && tx_req.valid && !tx_ok);
  c_stacked: cover property (conn_state == flo_pkg::FLO_CONN_ESTAB && tx_req.conn_req && tx_ok);
  c_stack_err: cover property ($rose(stack_err_reg));
  c_seq_only3: cover property (opts.seq3 && !opts.seq2);
endmodule

// [tb/flo_fabric_model.sv]
// Behavioural fabric port that builds the accept option word of each class group
`timescale 1ns/100ps
module flo_fabric_model (
  input wire logic [31:0] req_w0 [3],
  input wire logic [2:0] cap_cls,
  input wire logic [3:0] cap_opt,
  input wire logic both_bad,
  input wire logic noise,
  output logic [31:0] acc_w0 [3],
  output logic [31:0] acc_fill
);
  // Grant each option only where the node asked and the fabric is able
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      acc_w0[i] = {cap_cls[i], 31'h0};
      // reserved bits stay zero unless noise is commanded
      if (noise) begin
        acc_w0[i] = acc_w0[i] | ((i == 0) ? 32'h0fff_0000 : 32'h77ff_0000);
      end
      // in-order grant only in classes two and three
      if (i > 0) begin
        acc_w0[i][27] = req_w0[i][27] & cap_opt[0];
      end
    end
    acc_w0[0][30] = req_w0[0][30] & cap_opt[3];
    // at most one stacking mode unless told to misbehave
    acc_w0[0][29] = req_w0[0][29] & cap_opt[2];
    acc_w0[0][28] = req_w0[0][28] & cap_opt[1] & (~acc_w0[0][29] | both_bad);
    // control and size words carry junk only under noise
    acc_fill = noise ? 32'hffff_ffff : 32'h0;
  end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the fabric login option block
`timescale 1ns/100ps
module testbench;
  logic sys_clk, reset, bus_wr, bus_rd, rx_cr_ack, rx_cr_unidir, both_bad, noise, tx_ok, tx_fctl_unidir;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata, rv, acc_fill;
  logic [31:0] req_w0 [3];
  logic [31:0] acc_w0 [3];
  logic [2:0] cap_cls;
  logic [3:0] cap_opt;
  logic [23:0] conn_partner;
  flo_pkg::flo_txreq_s tx_req;
  flo_pkg::flo_conn_e conn_state;
  flo_pkg::flo_opts_s opts;
  int bad_count, total_checks;

  flo_top flo_top_i (.sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .tx_req(tx_req), .tx_ok(tx_ok),
    .tx_fctl_unidir(tx_fctl_unidir), .conn_state(conn_state), .conn_partner(conn_partner),
    .rx_cr_ack(rx_cr_ack), .rx_cr_unidir(rx_cr_unidir), .opts(opts));
  flo_fabric_model flo_fabric_model_i (.req_w0(req_w0), .cap_cls(cap_cls), .cap_opt(cap_opt),
    .both_bad(both_bad), .noise(noise), .acc_w0(acc_w0), .acc_fill(acc_fill));

  // Clock of 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    @(negedge sys_clk);
    d = bus_rdata;
  endtask

  task rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rv);
    chk(rv, exp);
  endtask

  // Expected functional options from the control word and the accept words
  function automatic logic [7:0] exp_opts(input logic [7:0] c);
    logic [2:0] v;
    v = {acc_w0[2][31] & c[2], acc_w0[1][31] & c[1], acc_w0[0][31] & c[0]};
    return {v, v[0] & c[3] & acc_w0[0][30], v[0] & c[3] & c[4] & acc_w0[0][29] & ~acc_w0[0][28],
      v[0] & c[3] & c[5] & acc_w0[0][28] & ~acc_w0[0][29], v[1] & c[6] & acc_w0[1][27],
      v[2] & c[7] & acc_w0[2][27]};
  endfunction

  // One full login: request, accept payload, evaluation, result
  task nego(input logic [7:0] c, input logic [2:0] cls, input logic [3:0] o, input logic bb, input logic nz);
    logic [31:0] s;
    wr(8'h00, {24'h0, c});
    cap_cls <= cls;
    cap_opt <= o;
    both_bad <= bb;
    noise <= nz;
    for (int g = 0; g < 3; g++) rd(8'h10 + 8'(g * 4), req_w0[g]);
    chk(req_w0[0], {c[0], c[3], c[3] & c[4], c[3] & c[5], 28'h0});
    chk(req_w0[1], {c[1], 3'h0, c[6], 27'h0});
    chk(req_w0[2], {c[2], 3'h0, c[7], 27'h0});
    for (int g = 0; g < 3; g++) begin
      for (int w = 0; w < 4; w++) wr(8'h40 + 8'(g * 16 + w * 4), (w == 0) ? acc_w0[g] : acc_fill);
    end
    rc(8'h50, acc_w0[1]);
    wr(8'h04, 32'h1);
    for (int n = 0; n < 12; n++) begin
      rd(8'h08, s);
      if (s[1]) break;
    end
    chk({31'h0, s[1]}, 32'h1);
    chk({24'h0, opts}, {24'h0, exp_opts(c)});
    chk({24'h0, s[4:2], s[5], s[6], s[7], s[8], s[9]}, {24'h0, exp_opts(c)});
    chk({31'h0, s[10]}, {31'h0, acc_w0[0][29] & acc_w0[0][28]});
  endtask

  // Offer one frame and look at the admission in the same cycle
  task adm(input logic [1:0] cl, input logic cr, input logic [23:0] d, input flo_pkg::flo_conn_e st,
    input logic ok, input logic un);
    @(posedge sys_clk);
    tx_req <= {1'b1, cl, cr, d};
    conn_state <= st;
    @(negedge sys_clk);
    chk({31'h0, tx_ok}, {31'h0, ok});
    chk({31'h0, tx_fctl_unidir}, {31'h0, un});
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    bad_count++;
    test_done();
  end

  initial begin
    reset = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    rx_cr_ack = 1'b0;
    rx_cr_unidir = 1'b0;
    tx_req = '0;
    conn_state = flo_pkg::FLO_CONN_IDLE;
    conn_partner = 24'h000011;
    cap_cls = 3'h0;
    cap_opt = 4'h0;
    both_bad = 1'b0;
    noise = 1'b0;
    req_w0 = '{default: 32'h0};
    bad_count = 0;
    total_checks = 0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rc(8'h00, 32'h0);
    rc(8'h08, 32'h0);
    chk({24'h0, opts}, 32'h0);
    rc(8'h20, 32'h0);
    wr(8'h00, 32'hffff_ffff);
    rc(8'h00, 32'h0000_00ff);
    $display("test reset_map done");
    nego(8'hff, 3'b111, 4'hf, 1'b0, 1'b1);
    adm(2'h1, 1'b1, 24'h000022, flo_pkg::FLO_CONN_ESTAB, 1'b1, 1'b0);
    adm(2'h2, 1'b0, 24'h000033, flo_pkg::FLO_CONN_ESTAB, 1'b1, 1'b0);
    $display("test transparent done");
    nego(8'hff, 3'b111, 4'b1011, 1'b0, 1'b0);
    adm(2'h1, 1'b1, 24'h000022, flo_pkg::FLO_CONN_PENDING, 1'b1, 1'b1);
    $display("test lockdown done");
    nego(8'hff, 3'b111, 4'hf, 1'b1, 1'b0);
    adm(2'h1, 1'b1, 24'h000022, flo_pkg::FLO_CONN_ESTAB, 1'b0, 1'b0);
    $display("test both_granted done");
    nego(8'hf7, 3'b101, 4'hf, 1'b0, 1'b0);
    adm(2'h1, 1'b0, 24'h000011, flo_pkg::FLO_CONN_ESTAB, 1'b1, 1'b0);
    adm(2'h1, 1'b0, 24'h000044, flo_pkg::FLO_CONN_ESTAB, 1'b0, 1'b0);
    adm(2'h3, 1'b0, 24'h000044, flo_pkg::FLO_CONN_ESTAB, 1'b0, 1'b0);
    adm(2'h3, 1'b0, 24'h000011, flo_pkg::FLO_CONN_ESTAB, 1'b1, 1'b0);
    adm(2'h2, 1'b0, 24'h000011, flo_pkg::FLO_CONN_IDLE, 1'b0, 1'b0);
    @(posedge sys_clk);
    rx_cr_ack <= 1'b1;
    rx_cr_unidir <= 1'b1;
    conn_state <= flo_pkg::FLO_CONN_ESTAB;
    @(posedge sys_clk);
    rx_cr_ack <= 1'b0;
    rx_cr_unidir <= 1'b0;
    adm(2'h1, 1'b0, 24'h000011, flo_pkg::FLO_CONN_ESTAB, 1'b0, 1'b0);
    adm(2'h1, 1'b0, 24'h000011, flo_pkg::FLO_CONN_IDLE, 1'b0, 1'b0);
    adm(2'h1, 1'b0, 24'h000011, flo_pkg::FLO_CONN_ESTAB, 1'b1, 1'b0);
    @(posedge sys_clk);
    rx_cr_ack <= 1'b1;
    @(posedge sys_clk);
    rx_cr_ack <= 1'b0;
    adm(2'h1, 1'b0, 24'h000011, flo_pkg::FLO_CONN_ESTAB, 1'b1, 1'b0);
    $display("test exclusive done");
    test_done();
  end
endmodule
